// *** design/ee_sel_consts.svh ***
// constants of the select, output-enable and write-protect block
// assumes a 50 MHz system clock and an spi host on the link pins
`ifndef EE_SEL_CONSTS_SVH
`define EE_SEL_CONSTS_SVH

// instruction codes
`define EE_CMD_STATUS_WR 8'h01
`define EE_CMD_ARRAY_WR 8'h02
`define EE_CMD_LATCH_CLR 8'h04
`define EE_CMD_STATUS_RD 8'h05
`define EE_CMD_LATCH_SET 8'h06

// byte counts of a complete sequence
`define EE_BYTES_ONE 3'h1
`define EE_BYTES_STATUS_WR 3'h2
`define EE_BYTES_WRITE_MIN 3'h4
`define EE_BYTES_MAX 3'h7

// status bit positions
`define EE_ST_BUSY 0
`define EE_ST_LATCH 1
`define EE_ST_BP_LO 2
`define EE_ST_BP_HI 3
`define EE_ST_PROT 7

// reset values
`define EE_STATUS_RESET 8'h00
`define EE_BP_RESET 2'h0

// timing
`define EE_CLK_PERIOD_NS 20
`define EE_TWC_NS 5000000
`define EE_TWC_CYCLES (`EE_TWC_NS / `EE_CLK_PERIOD_NS)

`endif

// *** design/ee_sel_pkg.sv ***
// types of the select, output-enable and write-protect block
// assumes the constants header is compiled alongside
`default_nettype none
package ee_sel_pkg;

    typedef enum logic {
        ST_IDLE,
        ST_WRITING
    } wr_state_t;

    typedef struct packed {
        logic protect_pin_enable_bit;
        logic [2:0] unused;
        logic [1:0] block_protect;
        logic write_latch_flag;
        logic write_busy_flag;
    } status_t;

    typedef struct packed {
        logic [7:0] cmd;
        logic [7:0] data;
        logic [2:0] bytes;
        logic aligned;
    } frame_t;

endpackage

`default_nettype wire

// *** design/ee_sel_protect.sv ***
// select, serial output enable, write protect and write timer of a serial eeprom
// assumes the host keeps serial clock still while chip select is high
// assumes chip select and write protect pins are asynchronous to clk_in
// assumes chip select idles high when reset is released
// Notes on behaviour
// - the device is selected while chip select is low and in standby while it is high and no programming cycle runs.
// - a started programming cycle runs to its end whatever chip select does.
// - with chip select high during a programming cycle, standby begins only when it ends.
// - while deselected the serial output is in high impedance.
// - the host raises chip select after a valid write sequence and that edge starts the timed write.
// - after power-up nothing is obeyed until chip select has fallen once.
// - during a read each new output bit is driven after a falling serial clock edge.
// - pin low with protect enable set refuses status writes while all else works.
// - pin high lets every function work, status writes included.
// - protect enable set and pin low during a status write sequence discards that write.
// - a pin falling after the internal write started leaves that write unaffected.
// - with protect enable clear the protect pin is ignored.
// - each serial input bit is captured on the rising serial clock edge.
// - the busy flag reads one during an internal write and zero otherwise.
`timescale 1ns/1ps
`default_nettype none
`include "ee_sel_consts.svh"

module ee_sel_protect #(
    parameter int unsigned TWC_CYCLES = `EE_TWC_CYCLES
) (
    // system
    input wire logic clk_in,
    input wire logic rstn_in,
    // link pins
    input wire logic sck_in,
    input wire logic cs_n_in,
    input wire logic si_in,
    input wire logic wp_n_in,
    output logic so_out,
    output logic so_oe_n_out,
    // state
    output logic selected_out,
    output logic standby_out,
    output ee_sel_pkg::status_t status_out,
    output logic array_commit_out
);

    function automatic logic seq_is(
        input ee_sel_pkg::frame_t f,
        input logic [7:0] code,
        input logic [2:0] nbytes
    );
        seq_is = (f.cmd == code) && (f.bytes == nbytes);
    endfunction

    function automatic logic [2:0] step3(
        input logic [2:0] v
    );
        step3 = v + 3'h1;
    endfunction

    // link domain
    logic in_frame;
    logic [2:0] bit_cnt;
    logic [7:0] shift;
    ee_sel_pkg::frame_t frame;
    logic frame_tog;
    ee_sel_pkg::status_t st_meta;
    ee_sel_pkg::status_t st_sync;
    logic armed_meta;
    logic armed_sync;
    logic armed;

    // link decode
    wire logic link_clr;
    wire logic first_edge;
    wire logic [2:0] cur_bit;
    wire logic [2:0] cur_bytes;
    wire logic byte_done;
    wire logic [7:0] next_shift;
    wire logic [2:0] next_bytes;
    wire logic reading;
    wire logic [2:0] out_idx;

    assign link_clr = !rstn_in || cs_n_in;
    assign first_edge = !in_frame;
    assign cur_bit = first_edge ? 3'h0 : bit_cnt;
    assign cur_bytes = first_edge ? 3'h0 : frame.bytes;
    assign byte_done = (cur_bit == 3'h7);
    assign next_shift = {(first_edge ? 7'h00 : shift[6:0]), si_in};
    assign next_bytes = (byte_done && cur_bytes != `EE_BYTES_MAX) ? step3(cur_bytes) : cur_bytes;
    assign reading = armed_sync && frame.cmd == `EE_CMD_STATUS_RD && frame.bytes != 3'h0;
    assign out_idx = 3'h7 - bit_cnt;

    // frame marker, cleared while deselected
    always_ff @(posedge sck_in or posedge link_clr) begin
        if (link_clr) begin
            in_frame <= 1'b0;
        end else begin
            in_frame <= 1'b1;
        end
    end

    // bit capture on rising serial clock
    always_ff @(posedge sck_in or negedge rstn_in) begin
        if (!rstn_in) begin
            bit_cnt <= 3'h0;
            shift <= 8'h00;
            frame <= '0;
            frame_tog <= 1'b0;
        end else begin
            bit_cnt <= step3(cur_bit);
            shift <= next_shift;
            frame.bytes <= next_bytes;
            frame.aligned <= byte_done;
            if (byte_done && cur_bytes == 3'h0) begin
                frame.cmd <= next_shift;
            end
            if (byte_done && cur_bytes == 3'h1) begin
                frame.data <= next_shift;
            end
            if (first_edge) begin
                frame_tog <= !frame_tog;
            end
        end
    end

    // status and arming brought into the link domain
    always_ff @(posedge sck_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_meta <= `EE_STATUS_RESET;
            st_sync <= `EE_STATUS_RESET;
            armed_meta <= 1'b0;
            armed_sync <= 1'b0;
        end else begin
            st_meta <= status_out;
            st_sync <= st_meta;
            armed_meta <= armed;
            armed_sync <= armed_meta;
        end
    end

    // serial output on falling serial clock, released when deselected
    always_ff @(negedge sck_in or posedge link_clr) begin
        if (link_clr) begin
            so_out <= 1'b0;
            so_oe_n_out <= 1'b1;
        end else begin
            so_out <= reading ? st_sync[out_idx] : 1'b0;
            so_oe_n_out <= !reading;
        end
    end

    // system domain
    logic cs_meta;
    logic cs_sync;
    logic cs_prev;
    logic tog_meta;
    logic tog_sync;
    logic tog_seen;
    logic wp_meta;
    logic wp_sync;
    logic wp_low_seen;
    ee_sel_pkg::wr_state_t wr_state;
    logic [31:0] timer;
    logic protect_en;
    logic [1:0] bp;
    logic latch;

    // frame decode
    wire logic cs_rise;
    wire logic cs_fall;
    wire logic busy;
    wire logic protect;
    wire logic valid;
    wire logic do_latch_set;
    wire logic do_latch_clr;
    wire logic do_status_wr;
    wire logic do_array_wr;
    wire logic start_wr;
    wire logic timer_done;
    wire ee_sel_pkg::status_t next_status;

    assign cs_rise = cs_sync && !cs_prev;
    assign cs_fall = !cs_sync && cs_prev;
    assign busy = (wr_state == ee_sel_pkg::ST_WRITING);
    assign protect = protect_en && (wp_low_seen || !wp_sync);
    assign valid = armed && cs_rise && (tog_sync != tog_seen) && frame.aligned && !busy;
    assign do_latch_set = valid && seq_is(frame, `EE_CMD_LATCH_SET, `EE_BYTES_ONE);
    assign do_latch_clr = valid && seq_is(frame, `EE_CMD_LATCH_CLR, `EE_BYTES_ONE);
    assign do_status_wr = valid && latch && !protect && seq_is(frame, `EE_CMD_STATUS_WR, `EE_BYTES_STATUS_WR);
    assign do_array_wr = valid && latch && frame.cmd == `EE_CMD_ARRAY_WR && frame.bytes >= `EE_BYTES_WRITE_MIN;
    assign start_wr = do_status_wr || do_array_wr;
    assign timer_done = (timer == 32'h0000_0001);

    // status word as the host reads it
    assign next_status.protect_pin_enable_bit = protect_en;
    assign next_status.unused = 3'h0;
    assign next_status.block_protect = bp;
    assign next_status.write_latch_flag = latch;
    assign next_status.write_busy_flag = busy;

    // pin synchronisers
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cs_meta <= 1'b1;
            cs_sync <= 1'b1;
            cs_prev <= 1'b1;
            tog_meta <= 1'b0;
            tog_sync <= 1'b0;
            wp_meta <= 1'b1;
            wp_sync <= 1'b1;
        end else begin
            cs_meta <= cs_n_in;
            cs_sync <= cs_meta;
            cs_prev <= cs_sync;
            tog_meta <= frame_tog;
            tog_sync <= tog_meta;
            wp_meta <= wp_n_in;
            wp_sync <= wp_meta;
        end
    end

    // arming and frame bookkeeping
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            armed <= 1'b0;
            tog_seen <= 1'b0;
            wp_low_seen <= 1'b0;
        end else begin
            if (cs_fall) begin
                armed <= 1'b1;
            end
            if (cs_rise) begin
                tog_seen <= tog_sync;
            end
            if (cs_fall) begin
                wp_low_seen <= !wp_sync;
            end else if (!cs_sync && !wp_sync) begin
                wp_low_seen <= 1'b1;
            end
        end
    end

    // write timer, independent of chip select and protect pin
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wr_state <= ee_sel_pkg::ST_IDLE;
            timer <= 32'h0000_0000;
        end else begin
            unique case (wr_state)
                ee_sel_pkg::ST_IDLE: begin
                    if (start_wr) begin
                        wr_state <= ee_sel_pkg::ST_WRITING;
                        timer <= TWC_CYCLES;
                    end
                end
                ee_sel_pkg::ST_WRITING: begin
                    timer <= timer - 32'h0000_0001;
                    if (timer_done) begin
                        wr_state <= ee_sel_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // status bits
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            protect_en <= 1'b0;
            bp <= `EE_BP_RESET;
            latch <= 1'b0;
        end else begin
            if (do_status_wr) begin
                protect_en <= frame.data[`EE_ST_PROT];
                bp <= frame.data[`EE_ST_BP_HI:`EE_ST_BP_LO];
            end
            if (busy && timer_done) begin
                latch <= 1'b0;
            end else if (do_latch_set) begin
                latch <= 1'b1;
            end else if (do_latch_clr) begin
                latch <= 1'b0;
            end
        end
    end

    // registered outputs
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            selected_out <= 1'b0;
            standby_out <= 1'b1;
            status_out <= `EE_STATUS_RESET;
            array_commit_out <= 1'b0;
        end else begin
            selected_out <= !cs_sync;
            standby_out <= cs_sync && !busy && !start_wr;
            status_out <= next_status;
            array_commit_out <= do_array_wr;
        end
    end

endmodule

`default_nettype wire

// *** tb/ee_sel_protect_assertions.sv ***
// checker of select, standby, status and commit timing
// bound to the select and protect block, sees only its ports
`timescale 1ns/1ps
`default_nettype none
module ee_sel_checker #(
    parameter int unsigned TWC_CYCLES = 20
) (
    // system
    input wire logic clk_in,
    input wire logic rstn_in,
    // link
    input wire logic cs_n_in,
    input wire logic so_oe_n_out,
    // state
    input wire logic selected_out,
    input wire logic standby_out,
    input wire ee_sel_pkg::status_t status_out,
    input wire logic array_commit_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    int unsigned busy_cnt;
    wire logic busy = status_out.write_busy_flag;
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            busy_cnt <= 0;
        end else begin
            busy_cnt <= busy ? busy_cnt + 1 : 0;
        end
    end
    sel_level_a: assert property (!cs_n_in [*4] |-> selected_out) else $error("select late");
    idle_standby_a: assert property ((cs_n_in && !busy) [*6] |-> standby_out) else $error("no standby");
    busy_standby_a: assert property (busy |-> !standby_out) else $error("standby in write");
    desel_hiz_a: assert property (cs_n_in |-> so_oe_n_out) else $error("output driven");
    commit_cause_a: assert property (array_commit_out |-> $past(cs_n_in, 3) ##1 !array_commit_out)
        else $error("bad commit");
    commit_busy_a: assert property (array_commit_out |-> ##[0:1] busy) else $error("no busy");
    write_len_a: assert property ($fell(busy) |-> busy_cnt == TWC_CYCLES) else $error("write length");
    latch_end_a: assert property ($fell(busy) |-> !status_out.write_latch_flag) else $error("latch kept");
    nv_change_a: assert property ($changed(status_out[7:2]) |-> $rose(busy)) else $error("status moved");
endmodule
bind ee_sel_protect ee_sel_checker #(.TWC_CYCLES(TWC_CYCLES)) chk (.clk_in(clk_in), .rstn_in(rstn_in),
    .cs_n_in(cs_n_in), .so_oe_n_out(so_oe_n_out), .selected_out(selected_out), .standby_out(standby_out),
    .status_out(status_out), .array_commit_out(array_commit_out));
`default_nettype wire

// *** tb/ee_sel_protect_tb.sv ***
// bench of the select and protect block with a host model
// assumes the design files are compiled first
`timescale 1ns/1ps
`default_nettype none
module ee_sel_protect_tb;
    localparam int unsigned TWC = 20;
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic wp_n = 1'b1;
    logic sck, cs_n, si, so, so_oe_n, selected, standby, commit;
    ee_sel_pkg::status_t status;
    int miscompares = 0;
    int checks = 0;
    int commits = 0;
    always #10 clk_in = ~clk_in;
    always @(posedge clk_in) if (commit === 1'b1) commits <= commits + 1;
    ee_sel_protect #(.TWC_CYCLES(TWC)) DUT (.clk_in(clk_in), .rstn_in(rstn_in), .sck_in(sck), .cs_n_in(cs_n),
        .si_in(si), .wp_n_in(wp_n), .so_out(so), .so_oe_n_out(so_oe_n), .selected_out(selected),
        .standby_out(standby), .status_out(status), .array_commit_out(commit));
    spi_host_model host (.sck_out(sck), .cs_n_out(cs_n), .si_out(si), .so_in(so), .so_oe_n_in(so_oe_n));
    task automatic wrap_up();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cmd(input logic [31:0] w, input int n, input int nrd = 0);
        host.frame(w, n, nrd);
        repeat (2) @(posedge clk_in);
    endtask
    task automatic pin(input logic v);
        @(posedge clk_in) wp_n <= v;
        repeat (3) @(posedge clk_in);
    endtask
    task automatic wait_idle();
        for (int i = 0; status.write_busy_flag !== 1'b0; i++) begin
            if (i > TWC + 8) begin
                miscompares++;
                wrap_up();
            end
            @(posedge clk_in);
        end
        @(posedge clk_in);
        check("standby", {7'h0, standby}, 8'h01);
    endtask
    task automatic s_latch();
        check("reset", status, 8'h00);
        check("select", {7'h0, selected}, 8'h00);
        cmd(32'h06000000, 8);
        check("wren", status, 8'h02);
        cmd(32'h04000000, 8);
        check("wrdi", status, 8'h00);
    endtask
    task automatic s_pin_ignored();
        pin(1'b0);
        cmd(32'h06000000, 8);
        cmd(32'h018C0000, 16);
        check("wrsr", status, 8'h8F);
        check("standby", {7'h0, standby}, 8'h00);
        wait_idle();
        check("wrsr end", status, 8'h8C);
    endtask
    task automatic s_protected();
        cmd(32'h06000000, 8);
        cmd(32'h01000000, 16);
        check("refused", status, 8'h8E);
        cmd(32'h05000000, 8, 8);
        check("rdsr", host.rd_byte, 8'h8E);
        check("so hiz", {7'h0, host.rd_hiz}, 8'h00);
        check("so off", {7'h0, so_oe_n}, 8'h01);
    endtask
    task automatic s_pin_high();
        pin(1'b1);
        cmd(32'h01840000, 16);
        check("wrsr", status, 8'h87);
        @(posedge clk_in) wp_n <= 1'b0;
        wait_idle();
        check("kept", status, 8'h84);
    endtask
    task automatic s_array();
        cmd(32'h06000000, 8);
        cmd(32'h02000000, 24);
        check("short", commits[7:0], 8'h00);
        cmd(32'h020000A5, 32);
        check("commit", commits[7:0], 8'h01);
        check("standby", {7'h0, standby}, 8'h00);
        cmd(32'h05000000, 8, 8);
        check("busy", host.rd_byte, 8'h87);
        wait_idle();
        check("idle", status, 8'h84);
    endtask
    initial begin
        repeat (5) @(posedge clk_in);
        rstn_in <= 1'b1;
        repeat (5) @(posedge clk_in);
        s_latch();
        s_pin_ignored();
        s_protected();
        s_pin_high();
        s_array();
        wrap_up();
    end
endmodule
`default_nettype wire

// *** tb/spi_host_model.sv ***
// host side of the link: frames on a 12 ns serial clock, idle low
// assumes the device updates its serial output on falling edges
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    // link pins
    output logic sck_out,
    output logic cs_n_out,
    output logic si_out,
    input wire logic so_in,
    input wire logic so_oe_n_in
);
    logic [7:0] rd_byte = 8'h00;
    logic rd_hiz = 1'b0;
    initial begin
        sck_out = 1'b0;
        cs_n_out = 1'b1;
        si_out = 1'b0;
    end
    // n bits msb first, then nrd bits read back
    task automatic frame(input logic [31:0] w, input int n, input int nrd);
        #3 rd_hiz = 1'b0;
        cs_n_out = 1'b0;
        for (int i = 0; i < n + nrd; i++) begin
            si_out = (i < n) ? w[31 - i] : ~si_out;
            #6 sck_out = 1'b1;
            if (i >= n) begin
                rd_byte = {rd_byte[6:0], so_oe_n_in ? ~so_in : so_in};
                rd_hiz = rd_hiz | so_oe_n_in;
            end
            #6 sck_out = 1'b0;
        end
        #12 cs_n_out = 1'b1;
        si_out = ~si_out;
        #100;
    endtask
endmodule
`default_nettype wire
